// ===== test_usb_frame_number_and_in_irq_flags.sv
`timescale 1ns/1ps
module test_usb_frame_number_and_in_irq_flags
  import ufi_pkg::*;
;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic clk = 1'b0;
  logic arst_n, sofGo, sofValid, extEn, usbIrq, cpuIrq, irqOut;
  ufi_req_s busReq;
  ufi_frame_s sofNum, sofFrame, fr;
  logic [IN_EP_N-1:0] epGo, inEpEvent, en, e;
  logic [DATA_W-1:0] rdData, q;
  logic [31:0] seed;
  int errorCnt = 0, samplesChecked = 0, cyc = 0;
  logic [7:0] ofs [7] = '{8'h02, 8'h07, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h3f};
  logic [7:0] rstv [7] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ufi_frame_irq ufi_frame_irq_inst (.clk(clk), .arst_n(arst_n),
    .busReq(busReq), .rdData(rdData), .sofValid(sofValid),
    .sofFrame(sofFrame), .inEpEvent(inEpEvent),
    .cpuExtIrqEnable(extEn), .usbIrq(usbIrq), .cpuIrq(cpuIrq),
    .irqOut(irqOut));
  ufi_host_model ufi_host_model_inst (.clk(clk), .arst_n(arst_n),
    .sofGo(sofGo), .sofNum(sofNum), .epGo(epGo), .sofValid(sofValid),
    .sofFrame(sofFrame), .inEpEvent(inEpEvent));

  // ==========================================================================
  // clock, timeout and helpers
  // ==========================================================================
  always #10 clk = ~clk;

  // whole run is well under a thousand cycles; generous ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errorCnt++;
      testDone();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic testDone();
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : testDone

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one strobe cycle; read data sampled in the cycle after it
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] r);
    @(posedge clk);
    busReq <= '{addr: a, wrData: d, wrStb: w, rdStb: ~w};
    @(posedge clk);
    busReq <= '0;
    #1 r = rdData;
  endtask : bus

  // token taken by the design two edges after the request
  task automatic sendSof(input ufi_frame_s f);
    @(posedge clk);
    sofGo  <= 1'b1;
    sofNum <= f;
    @(posedge clk);
    sofGo <= 1'b0;
    @(posedge clk);
  endtask : sendSof

  task automatic evt(input logic [3:0] v, input logic x);
    @(posedge clk);
    epGo  <= v;
    extEn <= x;
    @(posedge clk);
    epGo <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : evt

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    arst_n = 1'b0;
    busReq = '0;
    sofGo  = 1'b0;
    sofNum = '0;
    epGo   = '0;
    extEn  = 1'b0;
    seed = 32'h7eb33a1c;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    // values after reset, unmapped offset reads zero
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 8'h00, q);
      chk(q, rstv[i]);
    end
    // frame capture, writes to read-only frame registers ignored
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      fr = (i == 0) ? 11'h7ff : seed[10:0];
      sendSof(fr);
      bus(1'b1, 8'h0c, ~fr.low, q);
      bus(1'b1, 8'h0d, 8'hff, q);
      bus(1'b0, 8'h0c, 8'h00, q);
      chk(q, fr.low);
      bus(1'b0, 8'h0d, 8'h00, q);
      chk(q, {5'h00, fr.high});
    end
    // endpoint flags, enables, combined request, read-to-clear
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      en = (i == 0) ? 4'h1 : seed[3:0];
      e  = (i == 0) ? 4'hf : seed[7:4];
      bus(1'b1, 8'h07, {4'h0, en}, q);
      evt(e, seed[8]);
      chk({7'h00, usbIrq}, {7'h00, |(e & en)});
      chk({7'h00, cpuIrq}, {7'h00, |(e & en) & seed[8]});
      bus(1'b1, 8'h02, 8'hff, q);
      bus(1'b0, 8'h02, 8'h00, q);
      chk(q, {4'h0, e});
      // read data stand one cycle only, then fall back to zero
      @(posedge clk) #1;
      chk(rdData, 8'h00);
      bus(1'b0, 8'h02, 8'h00, q);
      chk(q, 8'h00);
      chk({7'h00, usbIrq}, 8'h00);
      chk({7'h00, cpuIrq}, 8'h00);
    end
    // event in the same cycle as the clearing read survives
    e = 4'ha;
    fork
      begin
        @(posedge clk);
        epGo <= e;
        @(posedge clk);
        epGo <= '0;
      end
      begin
        @(posedge clk);
        bus(1'b0, 8'h02, 8'h00, q);
      end
    join
    chk(q, 8'h00);
    bus(1'b0, 8'h02, 8'h00, q);
    chk(q, {4'h0, e});
    // status interrupt: clear, raise, mask, unmask, clear by writing one
    bus(1'b1, 8'h10, 8'h03, q);
    bus(1'b1, 8'h11, 8'h03, q);
    @(posedge clk) #1;
    chk({7'h00, irqOut}, 8'h00);
    sendSof(11'h155);
    @(posedge clk) #1;
    chk({7'h00, irqOut}, 8'h01);
    bus(1'b1, 8'h11, 8'h02, q);
    bus(1'b1, 8'h10, 8'h02, q);
    @(posedge clk) #1;
    chk({7'h00, irqOut}, 8'h00);
    bus(1'b1, 8'h11, 8'h01, q);
    @(posedge clk) #1;
    chk({7'h00, irqOut}, 8'h01);
    bus(1'b1, 8'h10, 8'h01, q);
    @(posedge clk) #1;
    chk({7'h00, irqOut}, 8'h00);
    bus(1'b0, 8'h10, 8'h00, q);
    chk(q, 8'h00);
    testDone();
  end
endmodule : test_usb_frame_number_and_in_irq_flags

// ===== ufi_frame_capture.sv
`timescale 1ns/1ps
module ufi_frame_capture
  import ufi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sofValid,
  input  wire ufi_frame_s sofFrame,
  output      ufi_frame_s frame
);

  // ==========================================================================
  // frame number holding register
  // ==========================================================================
  // both halves load on the same edge, never one without the other
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame.low  <= RST_FRAME_LOW;
      frame.high <= RST_FRAME_HIGH;
    end else if (sofValid) begin
      frame <= sofFrame;
    end
  end

endmodule : ufi_frame_capture

// ===== ufi_frame_irq.sv
`timescale 1ns/1ps
module ufi_frame_irq
  import ufi_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire ufi_req_s            busReq,
  output      logic [DATA_W-1:0]   rdData,
  input  wire logic                sofValid,
  input  wire ufi_frame_s          sofFrame,
  input  wire logic [IN_EP_N-1:0]  inEpEvent,
  input  wire logic                cpuExtIrqEnable,
  output      logic                usbIrq,
  output      logic                cpuIrq,
  output      logic                irqOut
);

  // ==========================================================================
  // address decode
  // ==========================================================================
  // shared by the read path and the write path
  function automatic ufi_sel_e decodeSel(input logic [ADDR_W-1:0] a);
    ufi_sel_e s;
    s = SEL_NONE;
    case (a)
      OFS_IN_FLAGS:   s = SEL_IN_FLAGS;
      OFS_IN_ENABLE:  s = SEL_IN_ENABLE;
      OFS_FRAME_LOW:  s = SEL_FRAME_LOW;
      OFS_FRAME_HIGH: s = SEL_FRAME_HIGH;
      OFS_EVT_STATUS: s = SEL_EVT_STATUS;
      OFS_EVT_MASK:   s = SEL_EVT_MASK;
      default:        s = SEL_NONE;
    endcase
    return s;
  endfunction : decodeSel

  ufi_sel_e             sel;
  logic                 rdFlags;
  logic                 wrEnable;
  logic                 wrEvtStatus;
  logic                 wrEvtMask;

  // strobes are one cycle, so each qualified strobe is a pulse too
  assign sel         = decodeSel(busReq.addr);
  assign rdFlags     = busReq.rdStb && (sel == SEL_IN_FLAGS);
  assign wrEnable    = busReq.wrStb && (sel == SEL_IN_ENABLE);
  assign wrEvtStatus = busReq.wrStb && (sel == SEL_EVT_STATUS);
  assign wrEvtMask   = busReq.wrStb && (sel == SEL_EVT_MASK);

  // ==========================================================================
  // frame number capture
  // ==========================================================================
  ufi_frame_s           frameNow;

  // token strobe comes from the serial engine on this clock, no sync
  ufi_frame_capture u_frame (
    .clk      (clk),
    .arst_n   (arst_n),
    .sofValid (sofValid),
    .sofFrame (sofFrame),
    .frame    (frameNow)
  );

  // ==========================================================================
  // endpoint pending flags
  // ==========================================================================
  logic [IN_EP_N-1:0]   inFlags;
  logic [IN_EP_N-1:0]   inFlagClr;

  // a read wipes the whole register, a write never touches it
  assign inFlagClr = rdFlags ? {IN_EP_N{1'b1}} : {IN_EP_N{1'b0}};

  ufi_sticky_flags #(
    .W   (IN_EP_N),
    .RST (RST_IN_FLAGS)
  ) u_inFlags (
    .clk      (clk),
    .arst_n   (arst_n),
    .setPulse (inEpEvent),
    .clrMask  (inFlagClr),
    .flags    (inFlags)
  );

  // ==========================================================================
  // endpoint enable register
  // ==========================================================================
  logic [IN_EP_N-1:0]   inEnable;

  // all enables on after reset, as after a bus reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inEnable <= RST_IN_ENABLE;
    end else if (wrEnable) begin
      inEnable <= busReq.wrData[IN_EP_N-1:0];
    end
  end

  // ==========================================================================
  // combined request toward the core
  // ==========================================================================
  logic                 next_usbIrq;

  // a disabled flag still latches, it only stays off the request line
  assign next_usbIrq = |(inFlags & inEnable);

  // registered so both outputs come straight from flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      usbIrq <= 1'b0;
    end else begin
      usbIrq <= next_usbIrq;
    end
  end

  // gated copy; same latency as usbIrq so the two agree in each cycle after one in which cpuExtIrqEnable is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuIrq <= 1'b0;
    end else begin
      cpuIrq <= next_usbIrq & cpuExtIrqEnable;
    end
  end

  // ==========================================================================
  // block event status, mask and interrupt
  // ==========================================================================
  logic [EVT_N-1:0]     evtSet;
  logic [EVT_N-1:0]     evtClr;
  logic [EVT_N-1:0]     evtStatus;
  logic [EVT_N-1:0]     evtMask;

  // token seen, and any endpoint event
  always_comb begin
    evtSet              = '0;
    evtSet[EVT_SOF_BIT] = sofValid;
    evtSet[EVT_IN_BIT]  = |inEpEvent;
  end

  // write one to clear; zeros leave bits alone
  assign evtClr = wrEvtStatus ? busReq.wrData[EVT_N-1:0] : {EVT_N{1'b0}};

  ufi_sticky_flags #(
    .W   (EVT_N),
    .RST (RST_EVT_STATUS)
  ) u_evtStatus (
    .clk      (clk),
    .arst_n   (arst_n),
    .setPulse (evtSet),
    .clrMask  (evtClr),
    .flags    (evtStatus)
  );

  // mask defaults closed so nothing fires before software is ready
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evtMask <= RST_EVT_MASK;
    end else if (wrEvtMask) begin
      evtMask <= busReq.wrData[EVT_N-1:0];
    end
  end

  // level output, held while an unmasked status bit stands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(evtStatus & evtMask);
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  logic [DATA_W-1:0]    next_rdData;

  // unmapped offsets and idle cycles read as zero
  always_comb begin
    next_rdData = RST_RD_DATA;
    if (busReq.rdStb) begin
      case (sel)
        SEL_IN_FLAGS:   next_rdData = {4'h0, inFlags};
        SEL_IN_ENABLE:  next_rdData = {4'h0, inEnable};
        SEL_FRAME_LOW:  next_rdData = frameNow.low;
        SEL_FRAME_HIGH: next_rdData = {5'h00, frameNow.high};
        SEL_EVT_STATUS: next_rdData = {6'h00, evtStatus};
        SEL_EVT_MASK:   next_rdData = {6'h00, evtMask};
        default:        next_rdData = RST_RD_DATA;
      endcase
    end
  end

  // data stand for exactly the one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= RST_RD_DATA;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_readLow;
    busReq.rdStb && (sel == SEL_FRAME_LOW);
  endsequence

  sequence s_readHigh;
    busReq.rdStb && (sel == SEL_FRAME_HIGH);
  endsequence

  sequence s_readFlags;
    busReq.rdStb && (sel == SEL_IN_FLAGS);
  endsequence

  sequence s_noNewEvent;
    inEpEvent == {IN_EP_N{1'b0}};
  endsequence

  // low byte of the frame appears one cycle after its read
  chk_frame_low_read: assert property (
    s_readLow |=> rdData == $past(frameNow.low)
  ) else $error("frame low byte read back wrong");

  // upper bits of the high register always read zero
  chk_frame_high_read: assert property (
    s_readHigh |=> (rdData[DATA_W-1:FRAME_HW] == 5'h00)
                   && (rdData[FRAME_HW-1:0] == $past(frameNow.high))
  ) else $error("frame high register read back wrong");

  // a write to the flag register with no event changes nothing
  chk_flags_no_write: assert property (
    (busReq.wrStb && (sel == SEL_IN_FLAGS)) ##0 s_noNewEvent
      |=> inFlags == $past(inFlags)
  ) else $error("pending flags changed by a software write");

  // enable register takes the written value
  chk_enable_write: assert property (
    wrEnable |=> inEnable == $past(busReq.wrData[IN_EP_N-1:0])
  ) else $error("enable register not updated by write");

  // request follows enabled pending flags with one cycle of delay
  chk_combined_req: assert property (
    (|(inFlags & inEnable)) |=> usbIrq
  ) else $error("combined request missing while a flag is pending");

  chk_combined_idle: assert property (
    !(|(inFlags & inEnable)) |=> !usbIrq
  ) else $error("combined request high with nothing pending");

  // processor request only when both source and enable agree
  chk_cpu_gate: assert property (
    cpuIrq |-> usbIrq && $past(cpuExtIrqEnable)
  ) else $error("processor request without its enable");

  chk_cpu_pass: assert property (
    (next_usbIrq && cpuExtIrqEnable) |=> cpuIrq
  ) else $error("processor request blocked with enable set");

  // read returns the flags, then leaves them all clear
  chk_read_clear: assert property (
    s_readFlags ##0 s_noNewEvent
      |=> (inFlags == {IN_EP_N{1'b0}})
          && (rdData == {4'h0, $past(inFlags)})
  ) else $error("flag read did not return and clear");

  // an event in the clearing cycle survives the read
  chk_set_wins: assert property (
    s_readFlags |=> (inFlags & $past(inEpEvent)) == $past(inEpEvent)
  ) else $error("endpoint event lost during flag read");

  // both halves move together, and only on a token
  chk_frame_pair: assert property (
    sofValid |=> frameNow == $past(sofFrame)
  ) else $error("frame halves not loaded together");

  chk_frame_hold: assert property (
    !sofValid |=> $stable(frameNow)
  ) else $error("frame number changed without a token");

  // event interrupt tracks unmasked status
  chk_evt_irq: assert property (
    (|(evtStatus & evtMask)) |=> irqOut ##0 $past(evtMask) != 2'h0
  ) else $error("event interrupt missing");


  // ==========================================================================
  // checks on the read path
  // ==========================================================================
  // idle cycles must read as zero so a late sample is never mistaken
  // for fresh data
  chk_rd_idle: assert property (
    !busReq.rdStb |=> rdData == RST_RD_DATA
  ) else $error("read data not zero outside the read cycle");

  // holes in the map read as zero rather than aliasing a register
  chk_unmapped_read: assert property (
    (busReq.rdStb && (sel == SEL_NONE)) |=> rdData == RST_RD_DATA
  ) else $error("unmapped offset read back nonzero");

  // enable register reads back what was last written
  chk_enable_read: assert property (
    (busReq.rdStb && (sel == SEL_IN_ENABLE))
      |=> rdData == {4'h0, $past(inEnable)}
  ) else $error("enable register read back wrong");

  // with no read and no event the flags must not move at all
  chk_flag_hold: assert property (
    !rdFlags ##0 s_noNewEvent |=> $stable(inFlags)
  ) else $error("pending flags changed with no event or read");

  // ==========================================================================
  // checks on the event status register
  // ==========================================================================
  sequence s_noEvtSet;
    !sofValid && (inEpEvent == {IN_EP_N{1'b0}});
  endsequence

  // each source sets its own status bit on the edge that sees it
  chk_evt_sof_set: assert property (
    sofValid |=> evtStatus[EVT_SOF_BIT]
  ) else $error("token did not set its status bit");

  chk_evt_ep_set: assert property (
    (|inEpEvent) |=> evtStatus[EVT_IN_BIT]
  ) else $error("endpoint event did not set its status bit");

  // write one to clear; only checked when no set competes that cycle
  chk_evt_w1c: assert property (
    wrEvtStatus ##0 s_noEvtSet
      |=> (evtStatus & $past(busReq.wrData[EVT_N-1:0])) == 2'h0
  ) else $error("event status bit not cleared by writing one");

  // level output drops one cycle after the last unmasked bit goes
  chk_evt_idle: assert property (
    !(|(evtStatus & evtMask)) |=> !irqOut
  ) else $error("event interrupt high with nothing unmasked");

endmodule : ufi_frame_irq

// ===== ufi_host_model.sv
`timescale 1ns/1ps
// ============================================================================
// host side: start-of-frame tokens and endpoint events
// ============================================================================
module ufi_host_model
  import ufi_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                sofGo,
  input  wire ufi_frame_s          sofNum,
  input  wire logic [IN_EP_N-1:0]  epGo,
  output      logic                sofValid,
  output      ufi_frame_s          sofFrame,
  output      logic [IN_EP_N-1:0]  inEpEvent
);
  // one-cycle token; frame lines toggle outside tokens so a stale
  // value can never be mistaken for a fresh capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sofValid  <= 1'b0;
      sofFrame  <= '0;
      inEpEvent <= '0;
    end else begin
      sofValid  <= sofGo;
      sofFrame  <= sofGo ? sofNum : ~sofFrame;
      inEpEvent <= epGo;
    end
  end
endmodule : ufi_host_model

// ===== ufi_pkg.sv
package ufi_pkg;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned FRAME_W   = 11;
  localparam int unsigned FRAME_LW  = 8;
  localparam int unsigned FRAME_HW  = 3;
  localparam int unsigned IN_EP_N   = 4;
  localparam int unsigned EVT_N     = 2;

  // ==========================================================================
  // register offsets in the indirect space
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_IN_FLAGS   = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_IN_ENABLE  = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_FRAME_LOW  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FRAME_HIGH = 8'h0d;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 8'h11;

  // ==========================================================================
  // field positions and values after reset
  // ==========================================================================
  localparam int unsigned EVT_SOF_BIT = 0;
  localparam int unsigned EVT_IN_BIT  = 1;

  localparam logic [IN_EP_N-1:0] RST_IN_FLAGS  = 4'h0;
  localparam logic [IN_EP_N-1:0] RST_IN_ENABLE = 4'hf;
  localparam logic [FRAME_LW-1:0] RST_FRAME_LOW  = 8'h00;
  localparam logic [FRAME_HW-1:0] RST_FRAME_HIGH = 3'h0;
  localparam logic [EVT_N-1:0]   RST_EVT_STATUS = 2'h0;
  localparam logic [EVT_N-1:0]   RST_EVT_MASK   = 2'h0;
  localparam logic [DATA_W-1:0]  RST_RD_DATA    = 8'h00;

  // read data appear this many cycles after the read strobe
  localparam int unsigned RD_LATENCY = 1;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [2:0] {
    SEL_NONE       = 3'b000,
    SEL_IN_FLAGS   = 3'b001,
    SEL_IN_ENABLE  = 3'b010,
    SEL_FRAME_LOW  = 3'b011,
    SEL_FRAME_HIGH = 3'b100,
    SEL_EVT_STATUS = 3'b101,
    SEL_EVT_MASK   = 3'b110
  } ufi_sel_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wrStb;
    logic              rdStb;
  } ufi_req_s;

  typedef struct packed {
    logic [FRAME_HW-1:0] high;
    logic [FRAME_LW-1:0] low;
  } ufi_frame_s;

endpackage : ufi_pkg

// ===== ufi_sticky_flags.sv
`timescale 1ns/1ps
module ufi_sticky_flags
  import ufi_pkg::*;
#(
  parameter int unsigned     W   = 4,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic [W-1:0]  setPulse,
  input  wire logic [W-1:0]  clrMask,
  output      logic [W-1:0]  flags
);

  // ==========================================================================
  // one sticky bit per lane
  // ==========================================================================
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // set beats clear so an event in the clearing cycle is kept
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          flags[i] <= RST[i];
        end else begin
          flags[i] <= (flags[i] & ~clrMask[i]) | setPulse[i];
        end
      end
    end
  endgenerate

endmodule : ufi_sticky_flags
